// *** rtl/sbg_pkg.sv ***
// sbg_pkg: register map, field positions and reset values of the serial
// baud rate generator block.
// assumes a single bus clock domain shared by every user of the package.
package sbg_pkg;

    // ****************************************************************
    // register offsets (byte registers on the plain register port)
    // ****************************************************************
    localparam logic [2:0] SBG_OFS_DIV_HIGH   = 3'h0; // divisor high + options
    localparam logic [2:0] SBG_OFS_DIV_LOW    = 3'h1; // divisor low byte
    localparam logic [2:0] SBG_OFS_CTRL       = 3'h2; // rx / tx enables
    localparam logic [2:0] SBG_OFS_IRQ_STATUS = 3'h3; // sticky event bits
    localparam logic [2:0] SBG_OFS_IRQ_MASK   = 3'h4; // event mask

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int SBG_BIT_BRK_IE   = 7; // break detect irq enable
    localparam int SBG_BIT_EDGE_IE  = 6; // rx edge irq enable
    localparam int SBG_BIT_STOP_SEL = 5; // stop bit count select
    localparam int SBG_DIV_HI_MSB   = 4; // divisor bits 12..8 in 4..0
    localparam int SBG_BIT_RX_EN    = 0; // control: receiver enable
    localparam int SBG_BIT_TX_EN    = 1; // control: transmitter enable
    localparam int SBG_EVT_BRK      = 0; // status/mask: break flag event
    localparam int SBG_EVT_EDGE     = 1; // status/mask: rx edge event
    localparam int SBG_EVT_TICK     = 2; // status/mask: bit period done
    localparam int SBG_NUM_EVT      = 3; // number of event bits

    // ****************************************************************
    // widths, reset values and counts
    // ****************************************************************
    localparam int SBG_DIV_W = 13; // combined divisor width
    localparam logic [7:0]  SBG_RST_DIV_HIGH = 8'h00;
    localparam logic [7:0]  SBG_RST_DIV_LOW  = 8'h04;
    localparam logic [7:0]  SBG_RST_CTRL     = 8'h00;
    localparam logic [7:0]  SBG_RST_MASK     = 8'h00;
    localparam logic [3:0]  SBG_OVERSAMPLE_LAST = 4'hf; // 16 ticks per bit
    localparam logic [12:0] SBG_DIV_ZERO = 13'h0000;
    localparam logic [12:0] SBG_DIV_ONE  = 13'h0001;

endpackage

// *** rtl/sbg_prescaler.sv ***
// sbg_prescaler: modulo divider producing the 16x sample tick and the
// bit-rate tick from the bus clock.
// assumes the divisor is stable except at the load of a new value.
`timescale 1ns/1ps
module sbg_prescaler (
    input  wire logic        i_clk_sys,   // bus clock
    input  wire logic        i_resetn,    // async reset, active low
    input  wire logic        i_run,       // generator allowed to count
    input  wire logic [12:0] i_divisor,   // modulo value, 0 = off
    output logic             o_tick16,    // one pulse per 1/16 bit
    output logic             o_bit_tick   // one pulse per bit period
);
    import sbg_pkg::*;

    // ****************************************************************
    // counters
    // ****************************************************************
    logic [12:0] div_cnt;     // counts bus clocks within one sample
    logic [3:0]  os_cnt;      // counts samples within one bit
    wire         active;      // generator switching at all
    wire         div_wrap;    // last bus clock of a sample period
    wire         os_wrap;     // last sample of a bit period

    // a zero divisor halts everything, so no flop toggles
    assign active   = i_run && (i_divisor != SBG_DIV_ZERO);
    // modulo-n count gives bus_clock / (16 * n)
    assign div_wrap = active && (div_cnt >= i_divisor - SBG_DIV_ONE);
    assign os_wrap  = div_wrap && (os_cnt == SBG_OVERSAMPLE_LAST);

    // divisor counter; held at zero while idle
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt <= SBG_DIV_ZERO;
        end else if (!active || div_wrap) begin
            div_cnt <= SBG_DIV_ZERO;
        end else begin
            div_cnt <= div_cnt + SBG_DIV_ONE;
        end
    end

    // oversample counter; 16 sample periods make one bit
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            os_cnt <= 4'h0;
        end else if (!active) begin
            os_cnt <= 4'h0;
        end else if (div_wrap) begin
            os_cnt <= os_cnt + 4'h1;
        end
    end

    // registered tick outputs
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tick16   <= 1'b0;
            o_bit_tick <= 1'b0;
        end else begin
            o_tick16   <= div_wrap;
            o_bit_tick <= os_wrap;
        end
    end

endmodule

// *** rtl/sbg_top.sv ***
// sbg_top: baud divisor registers, option bits, enables and interrupt
// logic of the serial baud rate generator.
// assumes the shifters sit outside and take the ticks, the stop select
// and the enables; the two status flags arrive as levels from them.
//
// Summary of operation
// - high half buffered until low half written
// - break irq while flag set and enabled
// - edge irq while flag set and enabled
// - stop select: 0 one, 1 two stops
// - divisor zero stops the generator
// - bit rate is bus clock over 16n
// - generator off until rx/tx first enabled
// - divisor bits form one 13-bit value
`timescale 1ns/1ps
module sbg_top (
    input  wire logic        i_clk_sys,          // bus clock, 20 MHz
    input  wire logic        i_resetn,           // async reset, active low
    input  wire logic [2:0]  i_addr,             // register offset
    input  wire logic [7:0]  i_wdata,            // write data
    input  wire logic        i_wr,               // write strobe
    input  wire logic        i_rd,               // read strobe
    output logic      [7:0]  o_rdata,            // read data, next cycle
    input  wire logic        i_break_detect_flag, // break flag level
    input  wire logic        i_rx_edge_flag,      // rx edge flag level
    output logic             o_stop_bit_count_sel, // 0 one, 1 two stops
    output logic             o_receiver_enable,    // to receiver
    output logic             o_transmitter_enable, // to transmitter
    output logic [12:0]      o_baud_divisor_value, // active divisor
    output logic             o_baud_run,          // generator counting
    output logic             o_tick16,            // 16x sample pulse
    output logic             o_bit_tick,          // bit period pulse
    output logic             o_serial_irq,        // flag interrupt req
    output logic             o_irq                // masked status irq
);
    import sbg_pkg::*;

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] div_high_buf;   // what software last wrote to high reg
    logic [4:0] div_high_act;   // working high divisor bits
    logic [7:0] div_low;        // low divisor byte, active at once
    logic [1:0] ctrl;           // receiver / transmitter enables
    logic       armed;          // set once rx or tx was enabled
    logic [SBG_NUM_EVT-1:0] irq_status; // sticky events
    logic [SBG_NUM_EVT-1:0] irq_mask;   // event mask
    logic       brk_q;          // break flag last cycle
    logic       edge_q;         // edge flag last cycle
    logic [7:0] next_rdata;     // read mux result

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire wr_high   = i_wr && (i_addr == SBG_OFS_DIV_HIGH);
    wire wr_low    = i_wr && (i_addr == SBG_OFS_DIV_LOW);
    wire wr_ctrl   = i_wr && (i_addr == SBG_OFS_CTRL);
    wire wr_mask   = i_wr && (i_addr == SBG_OFS_IRQ_MASK);
    wire rd_status = i_rd && (i_addr == SBG_OFS_IRQ_STATUS);

    // ****************************************************************
    // derived controls
    // ****************************************************************
    wire brk_ie  = div_high_buf[SBG_BIT_BRK_IE];
    wire edge_ie = div_high_buf[SBG_BIT_EDGE_IE];
    // enable bit written to one arms the generator for good
    wire en_write = wr_ctrl && (i_wdata[SBG_BIT_RX_EN] ||
                                i_wdata[SBG_BIT_TX_EN]);
    // rising edges of incoming flags and the bit tick are the sticky events
    wire brk_rise  = i_break_detect_flag && !brk_q;
    wire edge_rise = i_rx_edge_flag && !edge_q;
    wire [SBG_NUM_EVT-1:0] evt_set;

    assign evt_set[SBG_EVT_BRK]  = brk_rise;
    assign evt_set[SBG_EVT_EDGE] = edge_rise;
    assign evt_set[SBG_EVT_TICK] = o_bit_tick;

    // high bits join low byte as one combined divisor
    assign o_baud_divisor_value = {div_high_act, div_low};
    assign o_baud_run           = armed &&
                                  (o_baud_divisor_value != SBG_DIV_ZERO);
    // stop count select straight from the option bit
    assign o_stop_bit_count_sel = div_high_buf[SBG_BIT_STOP_SEL];
    assign o_receiver_enable    = ctrl[SBG_BIT_RX_EN];
    assign o_transmitter_enable = ctrl[SBG_BIT_TX_EN];
    // level requests follow the flags while enabled
    assign o_serial_irq = (brk_ie && i_break_detect_flag) ||
                          (edge_ie && i_rx_edge_flag);
    assign o_irq        = |(irq_status & irq_mask);

    // ****************************************************************
    // divisor registers
    // ****************************************************************
    // high write buffers the divisor bits and sets the option bits at once; the low write commits the divisor
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            div_high_buf <= SBG_RST_DIV_HIGH;
        end else if (wr_high) begin
            div_high_buf <= i_wdata;
        end
    end

    // low write loads low byte and transfers buffered high
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            div_high_act <= SBG_RST_DIV_HIGH[SBG_DIV_HI_MSB:0];
            div_low      <= SBG_RST_DIV_LOW;
        end else if (wr_low) begin
            div_high_act <= div_high_buf[SBG_DIV_HI_MSB:0];
            div_low      <= i_wdata;
        end
    end

    // ****************************************************************
    // control and arming
    // ****************************************************************
    // enables are plain bits; arming survives clearing them
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl  <= SBG_RST_CTRL[1:0];
            armed <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= i_wdata[1:0];
            end
            if (en_write) begin
                armed <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************
    // set beats the clear-on-read so no event is lost
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status <= '0;
            brk_q      <= 1'b0;
            edge_q     <= 1'b0;
        end else begin
            irq_status <= (rd_status ? '0 : irq_status) | evt_set;
            brk_q      <= i_break_detect_flag;
            edge_q     <= i_rx_edge_flag;
        end
    end

    // mask register, same layout as status
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_mask <= SBG_RST_MASK[SBG_NUM_EVT-1:0];
        end else if (wr_mask) begin
            irq_mask <= i_wdata[SBG_NUM_EVT-1:0];
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // high register reads back its buffered value, so software sees
    // what it wrote even before the low write commits it
    always_comb begin
        next_rdata = 8'h00;
        if (i_addr == SBG_OFS_DIV_HIGH) begin
            next_rdata = div_high_buf & 8'he_0 | {3'h0, div_high_buf[4:0]};
        end else if (i_addr == SBG_OFS_DIV_LOW) begin
            next_rdata = div_low;
        end else if (i_addr == SBG_OFS_CTRL) begin
            next_rdata = {6'h00, ctrl};
        end else if (i_addr == SBG_OFS_IRQ_STATUS) begin
            next_rdata = {5'h00, irq_status};
        end else if (i_addr == SBG_OFS_IRQ_MASK) begin
            next_rdata = {5'h00, irq_mask};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // generator
    // ****************************************************************
    // counts only when armed and divisor non-zero
    sbg_prescaler u_prescaler (
        .i_clk_sys  (i_clk_sys),
        .i_resetn   (i_resetn),
        .i_run      (armed),
        .i_divisor  (o_baud_divisor_value),
        .o_tick16   (o_tick16),
        .o_bit_tick (o_bit_tick)
    );

endmodule

// *** tb/sbg_top_sva.sv ***
// sbg_top_sva: port-level assertions for the baud generator block.
// assumes it is bound onto sbg_top and sees only its ports.
`timescale 1ns/1ps
module sbg_top_sva (
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic [2:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_break_detect_flag,
    input wire logic        i_rx_edge_flag,
    input wire logic        o_stop_bit_count_sel,
    input wire logic [12:0] o_baud_divisor_value,
    input wire logic        o_baud_run,
    input wire logic        o_tick16,
    input wire logic        o_bit_tick,
    input wire logic        o_serial_irq
);
    import sbg_pkg::*;
    // ****************************************************************
    // shadow state
    // ****************************************************************
    logic [7:0]  hi_sh;     // buffered high register
    logic [4:0]  hi_div;    // its divisor part
    logic        arm_sh;    // rx or tx enabled since reset
    logic [17:0] g16;       // cycles since the last 16x tick
    logic [17:0] gbit;      // cycles since the last bit tick
    logic        ok16;      // g16 spans a full undisturbed period
    logic        okbit;     // same for gbit
    logic [12:0] div_prev;  // divisor seen at the previous edge
    wire         chg = o_baud_divisor_value != div_prev;
    assign hi_div = hi_sh[4:0];
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // track writes; gaps are void after any divisor change or stop
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            hi_sh <= 8'h00;
            arm_sh <= 1'b0;
            g16 <= 18'h0;
            gbit <= 18'h0;
            ok16 <= 1'b0;
            okbit <= 1'b0;
            div_prev <= {5'h00, SBG_RST_DIV_LOW};
        end else begin
            div_prev <= o_baud_divisor_value;
            if (i_wr && i_addr == SBG_OFS_DIV_HIGH)
                hi_sh <= i_wdata;
            if (i_wr && i_addr == SBG_OFS_CTRL && i_wdata[1:0] != 2'b00)
                arm_sh <= 1'b1;
            g16 <= o_tick16 ? 18'h1 : g16 + 18'h1;
            gbit <= o_bit_tick ? 18'h1 : gbit + 18'h1;
            ok16 <= (!o_baud_run || chg) ? 1'b0 : (o_tick16 | ok16);
            okbit <= (!o_baud_run || chg) ? 1'b0 : (o_bit_tick | okbit);
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_high_buffered: assert property (i_wr && i_addr == SBG_OFS_DIV_HIGH
        |=> $stable(o_baud_divisor_value)) else $error("high write moved divisor");
    a_low_loads: assert property (i_wr && i_addr == SBG_OFS_DIV_LOW
        |=> o_baud_divisor_value == {$past(hi_div), $past(i_wdata)})
        else $error("divisor not loaded");
    a_stop_sel: assert property (
        o_stop_bit_count_sel == hi_sh[SBG_BIT_STOP_SEL]) else $error("stop sel");
    a_break_irq: assert property (
        hi_sh[7] && i_break_detect_flag |-> o_serial_irq) else $error("brk irq");
    a_edge_irq: assert property (
        hi_sh[6] && i_rx_edge_flag |-> o_serial_irq) else $error("edge irq");
    a_irq_cause: assert property (o_serial_irq |->
        (hi_sh[7] && i_break_detect_flag) || (hi_sh[6] && i_rx_edge_flag))
        else $error("stray serial irq");
    a_zero_off: assert property (
        o_baud_divisor_value == SBG_DIV_ZERO |-> !o_baud_run)
        else $error("runs at zero");
    a_unarmed_off: assert property (
        !arm_sh |-> !o_baud_run && !o_tick16) else $error("runs unarmed");
    a_tick_period: assert property (
        o_tick16 && ok16 && !chg |-> g16 == 18'(o_baud_divisor_value))
        else $error("16x tick period");
    a_bit_period: assert property (
        o_bit_tick && okbit && !chg |-> gbit == {1'b0, o_baud_divisor_value, 4'h0})
        else $error("bit tick period");
    c_bit: cover property (o_bit_tick);
    c_irq: cover property (o_serial_irq);
    c_load: cover property (i_wr && i_addr == SBG_OFS_DIV_LOW);
endmodule

bind sbg_top sbg_top_sva chk_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_break_detect_flag(i_break_detect_flag), .i_rx_edge_flag(i_rx_edge_flag),
    .o_stop_bit_count_sel(o_stop_bit_count_sel), .o_baud_run(o_baud_run),
    .o_baud_divisor_value(o_baud_divisor_value), .o_tick16(o_tick16),
    .o_bit_tick(o_bit_tick), .o_serial_irq(o_serial_irq));

// *** tb/sbg_remote.sv ***
// sbg_remote: far serial node as this block sees it: break and
// active-edge conditions, reported as level flags.
// assumes the bench commands each condition; flags drop on release.
`timescale 1ns/1ps
module sbg_remote (
    input  wire logic i_clk_sys,           // bus clock
    input  wire logic i_resetn,            // async reset, active low
    input  wire logic i_brk_cmd,           // hold a break on the line
    input  wire logic i_edge_cmd,          // make an edge on rx
    output logic      o_break_detect_flag, // break seen
    output logic      o_rx_edge_flag       // edge seen
);
    // one clock late, as a line synchroniser would be
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_break_detect_flag <= 1'b0;
            o_rx_edge_flag <= 1'b0;
        end else begin
            o_break_detect_flag <= i_brk_cmd;
            o_rx_edge_flag <= i_edge_cmd;
        end
    end
endmodule

// *** tb/sbg_top_bench.sv ***
// sbg_top_bench: self-checking bench for the baud generator block.
// assumes a 20 MHz bus clock; reads are checked from a queue.
`timescale 1ns/1ps
module sbg_top_bench;
    import sbg_pkg::*;
    logic        clk = 1'b0;     // bus clock
    logic        rstn = 1'b0;    // reset, active low
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;    // read answer due this cycle
    logic        brk_cmd = 1'b0;
    logic        edge_cmd = 1'b0;
    logic        brk_f, edge_f, stop_sel, tx_en, run, t16, tbit, sirq, irq;
    logic [7:0]  rdata, hv, lv;
    logic [12:0] div;
    logic [12:0] dv;             // divisor expected before a low write
    logic [7:0]  exp_q[$];       // expected read data, oldest first
    int          n_fail = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          g, d;

    always #25 clk = ~clk;

    sbg_top dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_break_detect_flag(brk_f), .i_rx_edge_flag(edge_f),
        .o_stop_bit_count_sel(stop_sel), .o_receiver_enable(),
        .o_transmitter_enable(tx_en), .o_baud_divisor_value(div),
        .o_baud_run(run), .o_tick16(t16), .o_bit_tick(tbit),
        .o_serial_irq(sirq), .o_irq(irq));
    sbg_remote far_u (.i_clk_sys(clk), .i_resetn(rstn), .i_brk_cmd(brk_cmd),
        .i_edge_cmd(edge_cmd), .o_break_detect_flag(brk_f),
        .o_rx_edge_flag(edge_f));

    task automatic chk(string nm, logic [17:0] e, logic [17:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // write ends at a falling edge so its effect can be sampled
    task automatic wr_reg(logic [2:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_reg(logic [2:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // cycles between two ticks; b picks the bit tick
    task automatic gap(bit b, output int n);
        int i;
        i = 0;
        while (i < 400 && !(b ? tbit : t16)) begin
            @(negedge clk);
            i++;
        end
        @(negedge clk);
        n = 1;
        while (n < 400 && !(b ? tbit : t16)) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d)
            chk("rdata", 18'(exp_q.pop_front()), 18'(rdata));
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test;
        end
    end

    initial begin
        d = $urandom(90150);
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(SBG_OFS_DIV_HIGH, SBG_RST_DIV_HIGH);
        rd_reg(SBG_OFS_DIV_LOW, SBG_RST_DIV_LOW);
        rd_reg(SBG_OFS_CTRL, SBG_RST_CTRL);
        rd_reg(SBG_OFS_IRQ_MASK, SBG_RST_MASK);
        wr_reg(3'h6, 8'hff);
        rd_reg(3'h6, 8'h00);
        chk("run", 18'h0, 18'(run));
        // both stop settings, divisor staged through the high half
        dv = {5'h00, SBG_RST_DIV_LOW};
        for (int k = 0; k < 2; k++) begin
            hv = {2'b00, k[0], 5'($urandom)};
            lv = 8'($urandom);
            wr_reg(SBG_OFS_DIV_HIGH, hv);
            chk("stop", 18'(hv[5]), 18'(stop_sel));
            chk("div", 18'(dv), 18'(div));
            rd_reg(SBG_OFS_DIV_HIGH, hv);
            wr_reg(SBG_OFS_DIV_LOW, lv);
            chk("div", 18'({hv[4:0], lv}), 18'(div));
            dv = {hv[4:0], lv};
        end
        wr_reg(SBG_OFS_CTRL, 8'h02);
        chk("tx en", 18'h1, 18'(tx_en));
        // rate: settle on two ticks, then measure
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 1 : $urandom_range(6, 2);
            wr_reg(SBG_OFS_DIV_HIGH, 8'h00);
            wr_reg(SBG_OFS_DIV_LOW, 8'(d));
            gap(1'b0, g);
            gap(1'b0, g);
            chk("tick16 gap", 18'(d), 18'(g));
            gap(1'b1, g);
            gap(1'b1, g);
            chk("bit gap", 18'(16 * d), 18'(g));
        end
        wr_reg(SBG_OFS_DIV_HIGH, 8'hc0);
        wr_reg(SBG_OFS_DIV_LOW, 8'h00);
        repeat (4) @(negedge clk);
        chk("run", 18'h0, 18'(run));
        chk("tick16", 18'h0, 18'(t16));
        rd_reg(SBG_OFS_IRQ_STATUS, 8'h04);
        wr_reg(SBG_OFS_IRQ_MASK, 8'h01);
        brk_cmd <= 1'b1;
        repeat (3) @(negedge clk);
        chk("serial irq", 18'h1, 18'(sirq));
        chk("irq", 18'h1, 18'(irq));
        rd_reg(SBG_OFS_IRQ_STATUS, 8'h01);
        @(negedge clk);
        chk("irq", 18'h0, 18'(irq));
        wr_reg(SBG_OFS_DIV_HIGH, 8'h40);
        wr_reg(SBG_OFS_DIV_LOW, 8'h00);
        chk("serial irq", 18'h0, 18'(sirq));
        edge_cmd <= 1'b1;
        repeat (3) @(negedge clk);
        chk("serial irq", 18'h1, 18'(sirq));
        chk("irq", 18'h0, 18'(irq));
        rd_reg(SBG_OFS_IRQ_STATUS, 8'h02);
        repeat (3) @(posedge clk);
        stop_test;
    end
endmodule
